// [hw/llm_pkg.sv]
// Shared types and constants for the legacy link mode control block.
package llm_pkg;

   // Pixel encodings carried on the video path.
   localparam logic [1:0] ENC_RGB    = 2'h0;   // Plain RGB, the only legacy encoding.
   localparam logic [1:0] ENC_YC444  = 2'h1;   // Luma/chroma 4:4:4.
   localparam logic [1:0] ENC_YC422  = 2'h2;   // Luma/chroma 4:2:2.

   // Widths of the pixel path.
   localparam int PIX_W   = 24;                // Pixel payload width in bits.
   localparam int FIFO_D  = 4;                 // Depth of the pixel buffer in words.

   // Clock rate and the audio-absent notice time.
   localparam int CLK_HZ        = 50_000_000;  // System clock rate in hertz.
   localparam int NOAUD_SHOW_MS = 2000;        // How long the no-audio notice stays up, in ms.
   localparam int NOAUD_CYC     = (CLK_HZ / 1000) * NOAUD_SHOW_MS;  // Same time in cycles.

   // Synchroniser bit positions of the pin inputs.
   localparam int SY_LCLK  = 0;                // Link clock.
   localparam int SY_NSRC  = 1;                // New source attached.
   localparam int SY_GUARD = 2;                // Guard band seen by the deserialiser.
   localparam int SY_ISL   = 3;                // Data island seen by the deserialiser.
   localparam int SY_AUD   = 4;                // Audio packet seen by the deserialiser.
   localparam int SY_DE    = 5;                // Active video seen by the deserialiser.
   localparam int SY_NSNK  = 6;                // New sink attached.
   localparam int SY_W     = 7;                // Width of the synchroniser.

   // One pixel word as offered by the video datapath.
   typedef struct packed {
      logic             de;                    // Active video when high, blanking when low.
      logic [1:0]       enc;                   // Requested pixel encoding.
      logic [PIX_W-1:0] data;                  // Pixel payload.
   } llm_pix_t;

   // One word as handed to the serial transmitter.
   typedef struct packed {
      llm_pix_t pix;                           // Pixel after the mode has been applied.
      logic     guard;                         // Send a guard band before this video period.
      logic     island;                        // This blanking word opens a data island.
   } llm_txw_t;

   // Transmitter mode states.
   typedef enum logic [1:0] {
      TXM_LEGACY  = 2'b00,                     // Legacy sink assumed: nothing checked yet, or discovery found no match.
      TXM_PROBING = 2'b01,                     // Capability discovery running.
      TXM_ENH     = 2'b10                      // Enhanced sink confirmed.
   } llm_txm_t;

endpackage : llm_pkg

// [hw/llm_fifo.sv]
// Small flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/10ps
module llm_fifo #(
   parameter int W = 8,                        // Word width.
   parameter int D = 4                         // Depth in words.
) (
   input  wire logic         clk,              // System clock.
   input  wire logic         rst,              // Synchronous reset, active high.
   input  wire logic         in_valid,         // Writer offers a word.
   output logic              in_ready,         // FIFO has room.
   input  wire logic [W-1:0] in_data,          // Word to store.
   output logic              out_valid,        // FIFO holds a word.
   input  wire logic         out_ready,        // Reader takes the word.
   output logic [W-1:0]      out_data          // Oldest word.
);
   localparam int AW = $clog2(D);              // Pointer width.

   logic [W-1:0] mem [D];                      // Storage, indexed by pointer.
   logic [AW-1:0] wp;                          // Write pointer.
   logic [AW-1:0] rp;                          // Read pointer.
   logic [AW:0]   cnt;                         // Words held.
   wire           push = in_valid && in_ready; // A word enters.
   wire           pop  = out_valid && out_ready; // A word leaves.

   assign in_ready  = (cnt != (AW+1)'(D));
   assign out_valid = (cnt != '0);
   assign out_data  = mem[rp];

   // Pointers and count; a full FIFO refuses, so back-pressure reaches the writer.
   always_ff @(posedge clk) begin
      if (rst) begin
         wp  <= '0;
         rp  <= '0;
         cnt <= '0;
      end else begin
         if (push) begin
            wp <= (wp == AW'(D-1)) ? '0 : wp + 1'b1;
         end
         if (pop) begin
            rp <= (rp == AW'(D-1)) ? '0 : rp + 1'b1;
         end
         cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   // Storage write; contents need no reset because count guards them.
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp] <= in_data;
      end
   end

endmodule : llm_fifo

// [hw/llm_mode_ctrl.sv]
// Legacy or enhanced mode control for both ends of a digital video link.
`timescale 1ns/10ps
module llm_mode_ctrl
   import llm_pkg::*;
#(
   parameter int NOAUD_CYCLES = NOAUD_CYC      // Notice length in cycles; shorten in simulation.
) (
   input  wire logic     I_CLK,                // System clock, 50 MHz.
   input  wire logic     I_SYS_RST,            // Synchronous reset, active high.
   // Transmit side.
   input  wire logic     I_TX_NEW_SINK,        // Pin: sink hot-plugged, level, high = new sink.
   input  wire logic     I_TX_PROBE,           // Discovery running, level.
   input  wire logic     I_TX_SINK_ENH,        // Discovery result: sink is enhanced, pulse.
   input  wire logic     I_TX_PIX_VALID,       // Pixel word offered.
   output logic          O_TX_PIX_READY,       // Pixel word taken.
   input  wire llm_pix_t I_TX_PIX,             // Pixel word.
   input  wire logic     I_TX_ISL_REQ,         // Packet path wants a data island.
   output logic          O_TX_ISL_GRANT,       // Island allowed in this mode.
   output logic          O_TX_WORD_VALID,      // Word for the serialiser.
   input  wire logic     I_TX_WORD_READY,      // Serialiser takes the word.
   output llm_txw_t      O_TX_WORD,            // Word after mode limits.
   output logic          O_TX_ENH,             // Transmitter in enhanced mode.
   input  wire logic     I_TX_WIDE_CONN,       // Product must use the wide dual-link connector.
   input  wire logic     I_TX_ALT_AUDIO,       // Alternate audio outputs exist.
   input  wire logic     I_TX_ALT_AUDIO_OK,    // Correct audio reaches the alternate outputs.
   output logic          O_TX_AUDIO_OMIT_OK,   // Audio may be left out of the link.
   // Receive side, all pins from the link.
   input  wire logic     I_RX_LINK_CLK,        // Link clock, sampled.
   input  wire logic     I_RX_NEW_SRC,         // Source newly attached, level.
   input  wire logic     I_RX_GUARD,           // Valid guard band decoded.
   input  wire logic     I_RX_ISLAND,          // Data island period decoded.
   input  wire logic     I_RX_AUDIO,           // Audio packet decoded.
   input  wire logic     I_RX_DE,              // Active video decoded.
   output logic          O_RX_ENH,             // Receiver in enhanced mode.
   output logic          O_RX_VIDEO_OK,        // Video accepted for display.
   output logic          O_RX_NO_AUDIO         // No-audio notice to the user.
);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers.

   logic [SY_W-1:0] sy1;                       // First stage, read only by the second.
   logic [SY_W-1:0] sy2;                       // Second stage, safe to use.
   logic            lclk_d;                    // Delayed link clock for edge finding.
   logic            nsnk_d;                    // Delayed new-sink level.
   logic            nsrc_d;                    // Delayed new-source level.

   // Every pin passes two flops before any logic looks at it.
   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         sy1    <= '0;
         sy2    <= '0;
         lclk_d <= 1'b0;
         nsnk_d <= 1'b0;
         nsrc_d <= 1'b0;
      end else begin
         sy1    <= {I_TX_NEW_SINK, I_RX_DE, I_RX_AUDIO, I_RX_ISLAND, I_RX_GUARD, I_RX_NEW_SRC, I_RX_LINK_CLK};
         sy2    <= sy1;
         lclk_d <= sy2[SY_LCLK];
         nsnk_d <= sy2[SY_NSNK];
         nsrc_d <= sy2[SY_NSRC];
      end
   end

   wire lclk_rise = sy2[SY_LCLK] && !lclk_d;   // One cycle per rising link clock edge.
   wire new_sink  = sy2[SY_NSNK] && !nsnk_d;   // Sink attach event.
   wire new_src   = sy2[SY_NSRC] && !nsrc_d;   // Source attach event.

   ////////////////////////////////////////////////////////////////////////////
   // Transmit mode state.

   llm_txm_t txm;                              // Current transmit mode.
   llm_txm_t next_txm;                         // Mode for the next cycle.

   // Attach events beat discovery results, so a stale result cannot
   // promote a sink that has just been swapped.
   always_comb begin
      next_txm = txm;
      unique case (txm)
         TXM_LEGACY: begin
            if (I_TX_PROBE) begin
               next_txm = TXM_PROBING;
            end
         end
         TXM_PROBING: begin
            if (I_TX_SINK_ENH) begin
               next_txm = TXM_ENH;
            end else if (!I_TX_PROBE) begin
               next_txm = TXM_LEGACY;      // Discovery ended without a match.
            end
         end
         TXM_ENH: begin
            next_txm = TXM_ENH;
         end
         default: begin
            next_txm = TXM_LEGACY;
         end
      endcase
      if (new_sink) begin
         next_txm = TXM_LEGACY;
      end
   end

   // Reset returns to the legacy assumption.
   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         txm <= TXM_LEGACY;
      end else begin
         txm <= next_txm;
      end
   end

   wire tx_enh = (txm == TXM_ENH);             // Enhanced behaviour allowed.

   ////////////////////////////////////////////////////////////////////////////
   // Transmit pixel path: buffer, then apply the mode limits.

   logic     fifo_valid;                       // Buffered word available.
   logic     fifo_take;                        // Output stage takes a word.
   llm_pix_t fifo_pix;                         // Buffered word.
   llm_txw_t next_word;                        // Word after mode limits.
   logic     word_valid;                       // Output stage holds a word.

   llm_fifo #(
      .W ($bits(llm_pix_t)),
      .D (FIFO_D)
   ) u_pix_fifo (
      .clk       (I_CLK),
      .rst       (I_SYS_RST),
      .in_valid  (I_TX_PIX_VALID),
      .in_ready  (O_TX_PIX_READY),
      .in_data   (I_TX_PIX),
      .out_valid (fifo_valid),
      .out_ready (fifo_take),
      .out_data  (fifo_pix)
   );

   // The output stage reloads when empty or when the serialiser takes its word.
   assign fifo_take = !word_valid || I_TX_WORD_READY;

   // Island grant needs enhanced mode and a request; a legacy link never gets one.
   assign O_TX_ISL_GRANT = tx_enh && I_TX_ISL_REQ;

   // Legacy and probing modes strip everything a legacy sink cannot parse.
   assign next_word.pix.de   = fifo_pix.de;
   assign next_word.pix.data = fifo_pix.data;
   assign next_word.pix.enc  = tx_enh ? fifo_pix.enc : ENC_RGB;
   assign next_word.guard    = tx_enh && fifo_pix.de;
   assign next_word.island   = O_TX_ISL_GRANT && !fifo_pix.de;

   // Registered output stage; data comes from flops.
   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         word_valid <= 1'b0;
         O_TX_WORD  <= '0;
      end else if (fifo_take) begin
         word_valid <= fifo_valid;
         O_TX_WORD  <= next_word;
      end
   end

   assign O_TX_WORD_VALID = word_valid;
   assign O_TX_ENH        = tx_enh;

   // All three conditions must hold together before audio may be left out.
   assign O_TX_AUDIO_OMIT_OK = I_TX_WIDE_CONN && I_TX_ALT_AUDIO && I_TX_ALT_AUDIO_OK;

   ////////////////////////////////////////////////////////////////////////////
   // Receive mode and audio presence.

   logic rx_enh;                               // Receiver in enhanced mode.
   logic rx_de;                                // Active video seen at last link edge.
   logic rx_aud;                               // Audio seen since the last source attach or reset.
   logic rx_aud_seen;                          // Audio ever seen in this session.

   // A guard band or island is taken as proof of an enhanced source; an
   // attach event wins over a same-cycle indication so the new source
   // starts from the legacy assumption.
   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         rx_enh <= 1'b0;
      end else if (new_src) begin
         rx_enh <= 1'b0;
      end else if (lclk_rise && (sy2[SY_GUARD] || sy2[SY_ISL])) begin
         rx_enh <= 1'b1;
      end
   end

   // Link-side levels are taken only on link clock edges, so a stopped
   // link clock freezes them instead of letting them drift.
   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST || new_src) begin
         rx_de       <= 1'b0;
         rx_aud_seen <= 1'b0;
      end else if (lclk_rise) begin
         rx_de <= sy2[SY_DE];
         if (sy2[SY_AUD]) begin
            rx_aud_seen <= 1'b1;
         end
      end
   end

   assign rx_aud = rx_aud_seen;

   // Video is accepted with or without audio; a legacy source never carries it.
   assign O_RX_VIDEO_OK = rx_de;
   assign O_RX_ENH      = rx_enh;

   ////////////////////////////////////////////////////////////////////////////
   // Temporary no-audio notice.

   logic [31:0] show_cnt;                      // Remaining notice cycles.
   logic        shown;                         // Notice already given for this source.
   wire         want_notice = rx_de && !rx_aud && !shown; // Video up, audio missing.

   // The notice shows once per attached source, then clears itself so it
   // does not stay on the screen for good.
   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST || new_src) begin
         show_cnt <= '0;
         shown    <= 1'b0;
      end else if (want_notice) begin
         show_cnt <= 32'(NOAUD_CYCLES);
         shown    <= 1'b1;
      end else if (rx_aud) begin
         show_cnt <= '0;                   // Audio arrived, drop the notice.
      end else if (show_cnt != '0) begin
         show_cnt <= show_cnt - 32'h1;
      end
   end

   assign O_RX_NO_AUDIO = (show_cnt != '0);

endmodule : llm_mode_ctrl

// [bench/llm_mode_ctrl_asserts.sv]
// Port-level checks of the legacy link mode control.
`timescale 1ns/10ps
module llm_mode_ctrl_asserts
   import llm_pkg::*;
#(
   parameter int NOAUD_CYCLES = 50              // No-audio notice length in cycles.
) (
   input wire logic     I_CLK,                  // System clock.
   input wire logic     I_SYS_RST,              // Synchronous reset.
   input wire logic     I_TX_NEW_SINK,          // New sink pin.
   input wire logic     I_TX_ISL_REQ,           // Island request.
   input wire logic     O_TX_ISL_GRANT,         // Island grant.
   input wire logic     O_TX_WORD_VALID,        // Word valid.
   input wire llm_txw_t O_TX_WORD,              // Word to serialiser.
   input wire logic     O_TX_ENH,               // Transmit enhanced.
   input wire logic     I_TX_WIDE_CONN,         // Wide connector.
   input wire logic     I_TX_ALT_AUDIO,         // Alternate outputs.
   input wire logic     I_TX_ALT_AUDIO_OK,      // Alternate audio good.
   input wire logic     O_TX_AUDIO_OMIT_OK,     // Audio may be left out.
   input wire logic     I_RX_NEW_SRC,           // New source pin.
   input wire logic     O_RX_ENH,               // Receive enhanced.
   input wire logic     O_RX_NO_AUDIO           // No-audio notice.
);
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_SYS_RST);
   logic [31:0] noaud_cnt;                      // Cycles the notice has stood.
   // Count the notice so its length is bounded without a long repetition.
   always_ff @(posedge I_CLK) begin
      noaud_cnt <= (I_SYS_RST || !O_RX_NO_AUDIO) ? 32'h0 : noaud_cnt + 32'h1;
   end
   ////////////////////////////////////////////////////////////////////////////
   AST_TX_RGB: assert property (O_TX_WORD_VALID && !O_TX_ENH |-> O_TX_WORD.pix.enc == ENC_RGB)
      else $error("legacy word is not RGB");
   AST_TX_NOGUARD: assert property (O_TX_WORD_VALID && !O_TX_ENH |-> !O_TX_WORD.guard)
      else $error("legacy word carries a guard band");
   AST_TX_NOISL: assert property (O_TX_WORD_VALID && !O_TX_ENH |-> !O_TX_WORD.island)
      else $error("legacy word opens an island");
   AST_TX_NOGRANT: assert property (!O_TX_ENH |-> !O_TX_ISL_GRANT)
      else $error("island granted in legacy mode");
   AST_TX_ENH_GUARD: assert property (O_TX_WORD_VALID && O_TX_ENH && O_TX_WORD.pix.de |-> O_TX_WORD.guard)
      else $error("enhanced video without guard band");
   AST_TX_ENH_GRANT: assert property (I_TX_ISL_REQ && O_TX_ENH |-> O_TX_ISL_GRANT)
      else $error("island refused in enhanced mode");
   AST_TX_RST: assert property ($past(I_SYS_RST) |-> !O_TX_ENH)
      else $error("transmitter not legacy after reset");
   AST_TX_SINK: assert property ($rose(I_TX_NEW_SINK) |-> ##[1:6] !O_TX_ENH)
      else $error("new sink did not force legacy");
   AST_RX_RST: assert property ($past(I_SYS_RST) |-> !O_RX_ENH)
      else $error("receiver not legacy after reset");
   AST_RX_SRC: assert property ($rose(I_RX_NEW_SRC) |-> ##[1:6] (!O_RX_ENH && !O_RX_NO_AUDIO))
      else $error("new source did not restore legacy");
   AST_OMIT: assert property (O_TX_AUDIO_OMIT_OK == (I_TX_WIDE_CONN && I_TX_ALT_AUDIO && I_TX_ALT_AUDIO_OK))
      else $error("audio omission permission wrong");
   AST_NOAUD_LEN: assert property (noaud_cnt <= NOAUD_CYCLES)
      else $error("no-audio notice stands too long");
endmodule : llm_mode_ctrl_asserts
bind llm_mode_ctrl llm_mode_ctrl_asserts #(.NOAUD_CYCLES(NOAUD_CYCLES)) i_chk (.I_CLK, .I_SYS_RST,
   .I_TX_NEW_SINK, .I_TX_ISL_REQ, .O_TX_ISL_GRANT, .O_TX_WORD_VALID, .O_TX_WORD, .O_TX_ENH,
   .I_TX_WIDE_CONN, .I_TX_ALT_AUDIO, .I_TX_ALT_AUDIO_OK, .O_TX_AUDIO_OMIT_OK, .I_RX_NEW_SRC,
   .O_RX_ENH, .O_RX_NO_AUDIO);

// [bench/llm_link_src.sv]
// Behavioural far-end transmitter that drives the receive pins.
`timescale 1ns/10ps
module llm_link_src (
   input  wire logic       i_run,               // Frame active, link clock runs.
   input  wire logic [1:0] i_mode,              // Bit 0 sends guard bands, bit 1 islands.
   input  wire logic       i_aud,               // Audio packets inside islands.
   output logic            o_lclk,              // Link clock, still outside frames.
   output logic            o_guard,             // Guard band decoded.
   output logic            o_isl,               // Data island decoded.
   output logic            o_aud,               // Audio packet decoded.
   output logic            o_de                 // Active video.
);
   // The link clock only runs within frames, as a real source would idle it.
   initial begin
      {o_lclk, o_guard, o_isl, o_aud, o_de} = 5'h00;
      forever begin
         #80;
         o_lclk = i_run ? ~o_lclk : 1'b0;
      end
   end
   // Lines change on the falling link edge so they are steady at the rise.
   // Outside frames they drop to idle, so no stale indication survives a stop.
   always @(negedge o_lclk or negedge i_run) begin
      if (!i_run) begin
         {o_guard, o_isl, o_aud, o_de} = 4'h0;
      end else begin
         o_de    = ~o_de;
         o_guard = i_mode[0] & o_de;
         o_isl   = i_mode[1] & ~o_de;
         o_aud   = i_aud & i_mode[1] & ~o_de;
      end
   end
endmodule : llm_link_src

// [bench/llm_mode_ctrl_tb.sv]
// Self-checking bench of the legacy link mode control.
`timescale 1ns/10ps
module llm_mode_ctrl_tb;
   import llm_pkg::*;
   localparam int NOAUD = 50;                   // Shortened notice length.
   logic I_CLK = 0, I_SYS_RST = 1, I_TX_NEW_SINK = 0, I_TX_PROBE = 0, I_TX_SINK_ENH = 0;
   logic I_TX_PIX_VALID = 0, I_TX_ISL_REQ = 1, I_TX_WORD_READY = 1, I_RX_NEW_SRC = 0;
   logic I_TX_WIDE_CONN = 0, I_TX_ALT_AUDIO = 0, I_TX_ALT_AUDIO_OK = 0;
   llm_pix_t I_TX_PIX = '0;                     // Pixel offered.
   logic O_TX_PIX_READY, O_TX_ISL_GRANT, O_TX_WORD_VALID, O_TX_ENH, O_TX_AUDIO_OMIT_OK;
   logic O_RX_ENH, O_RX_VIDEO_OK, O_RX_NO_AUDIO, lclk, rguard, risl, raud, rde;
   llm_txw_t O_TX_WORD, got_w;                  // Word out and its captured copy.
   logic src_run = 0, src_aud = 0, tb_enh = 0, took = 0;
   logic [1:0] src_mode = 2'h0;                 // Far-end indication mode.
   logic [31:0] seed = 32'h661365EC;            // Random state.
   llm_pix_t sent[$];                           // Pixels taken, in order.
   int fails = 0, checks = 0, k, n, m;
   always #10 I_CLK = ~I_CLK;
   llm_mode_ctrl #(.NOAUD_CYCLES(NOAUD)) i_dut (.I_CLK, .I_SYS_RST, .I_TX_NEW_SINK, .I_TX_PROBE,
      .I_TX_SINK_ENH, .I_TX_PIX_VALID, .O_TX_PIX_READY, .I_TX_PIX, .I_TX_ISL_REQ, .O_TX_ISL_GRANT,
      .O_TX_WORD_VALID, .I_TX_WORD_READY, .O_TX_WORD, .O_TX_ENH, .I_TX_WIDE_CONN, .I_TX_ALT_AUDIO,
      .I_TX_ALT_AUDIO_OK, .O_TX_AUDIO_OMIT_OK, .I_RX_LINK_CLK(lclk), .I_RX_NEW_SRC,
      .I_RX_GUARD(rguard), .I_RX_ISLAND(risl), .I_RX_AUDIO(raud), .I_RX_DE(rde), .O_RX_ENH,
      .O_RX_VIDEO_OK, .O_RX_NO_AUDIO);
   llm_link_src i_src (.i_run(src_run), .i_mode(src_mode), .i_aud(src_aud), .o_lclk(lclk),
      .o_guard(rguard), .o_isl(risl), .o_aud(raud), .o_de(rde));
   ////////////////////////////////////////////////////////////////////////////
   // Galois-free shift register step; taps 32, 22, 2, 1.
   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction : rnd
   // Random pixel with an encoding the design accepts.
   function automatic llm_pix_t rnd_pix();
      logic [31:0] r;
      r = rnd();
      return '{de: r[0], enc: (r[2:1] == 2'h3) ? ENC_YC422 : r[2:1], data: r[31:8]};
   endfunction : rnd_pix
   // What the serialiser must see for a pixel in a given mode.
   function automatic llm_txw_t exp_word(input llm_pix_t p, input logic e);
      llm_txw_t w;
      w = '{pix: p, guard: e & p.de, island: e & ~p.de};
      if (!e) w.pix.enc = ENC_RGB;
      return w;
   endfunction : exp_word
   task automatic chk_word(input llm_txw_t g, input llm_txw_t e);
      checks++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH t=%0t word %h expected %h", $time, g, e);
      end
   endtask : chk_word
   task automatic chk_bit(input logic g, input logic e, input string s);
      checks++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH t=%0t %s is %b", $time, s, g);
      end
   endtask : chk_bit
   task automatic give_verdict();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict
   // Offer n random pixels with a stalling serialiser, then drain.
   task automatic stream(input int cnt);
      int g;
      k = 0;
      g = 0;
      I_TX_PIX_VALID = (cnt > 0);
      I_TX_PIX = rnd_pix();
      while (k < cnt && g < 2000) begin
         @(negedge I_CLK);
         g++;
         I_TX_WORD_READY = rnd() % 3 != 0;
         I_TX_ISL_REQ = tb_enh || rnd() % 2 != 0;
         if (took) begin
            k++;
            I_TX_PIX = rnd_pix();
         end
      end
      I_TX_PIX_VALID = 0;
      I_TX_WORD_READY = 1;
      I_TX_ISL_REQ = 1;
      repeat (60) @(negedge I_CLK);
      chk_bit(sent.size() == 0, 1'b1, "drain");
   endtask : stream
   ////////////////////////////////////////////////////////////////////////////
   // Scoreboard: record takes and judge each word the serialiser accepts.
   always @(posedge I_CLK) begin
      took = I_TX_PIX_VALID && O_TX_PIX_READY === 1'b1 && !I_SYS_RST;
      if (took) sent.push_back(I_TX_PIX);
      if (O_TX_WORD_VALID === 1'b1 && I_TX_WORD_READY && !I_SYS_RST) begin
         got_w = O_TX_WORD;
         chk_word(got_w, exp_word(sent.pop_front(), tb_enh));
      end
   end
   // Permission inputs wander at random so the omission logic is exercised.
   always @(negedge I_CLK) {I_TX_WIDE_CONN, I_TX_ALT_AUDIO, I_TX_ALT_AUDIO_OK} = 3'(rnd() % 8);
   // Watchdog sized well past the expected run of some 20 us.
   initial begin
      #400000;
      fails++;
      give_verdict();
   end
   initial begin
      repeat (6) @(negedge I_CLK);
      I_SYS_RST = 0;
      @(negedge I_CLK);
      chk_bit(O_TX_ENH, 1'b0, "tx mode after reset");
      chk_bit(O_RX_ENH, 1'b0, "rx mode after reset");
      stream(40);                               // Legacy traffic.
      // Hold the serialiser off until the buffer refuses: 4 words plus the stage.
      I_TX_WORD_READY = 0;
      I_TX_PIX_VALID = 1;
      n = 0;
      repeat (12) begin
         @(negedge I_CLK);
         if (took) n++;
         if (took) I_TX_PIX = rnd_pix();
      end
      chk_bit(n == FIFO_D + 1 && O_TX_PIX_READY === 1'b0, 1'b1, "buffer full");
      stream(0);
      I_TX_PROBE = 1;                           // Discovery stays legacy.
      stream(12);
      chk_bit(O_TX_ENH, 1'b0, "probing mode");
      I_TX_SINK_ENH = 1;
      @(negedge I_CLK);
      I_TX_SINK_ENH = 0;
      repeat (4) @(negedge I_CLK);
      chk_bit(O_TX_ENH, 1'b1, "enhanced sink");
      tb_enh = 1;
      stream(40);
      I_TX_PROBE = 0;
      I_TX_NEW_SINK = 1;                        // Hot plug returns to legacy.
      repeat (6) @(negedge I_CLK);
      tb_enh = 0;
      chk_bit(O_TX_ENH, 1'b0, "new sink");
      I_TX_NEW_SINK = 0;
      stream(20);
      // Receive side: a legacy source without audio.
      src_run = 1;
      n = 0;
      while (O_RX_VIDEO_OK !== 1'b1 && n < 100) begin @(negedge I_CLK); n++; end
      chk_bit(O_RX_VIDEO_OK, 1'b1, "video without audio");
      n = 0;
      while (O_RX_NO_AUDIO !== 1'b1 && n < 200) begin @(negedge I_CLK); n++; end
      n = 0;
      while (O_RX_NO_AUDIO === 1'b1 && n < 200) begin @(negedge I_CLK); n++; end
      chk_bit(n == NOAUD, 1'b1, "notice length");
      chk_bit(O_RX_ENH, 1'b0, "legacy source");
      for (m = 1; m < 3; m++) begin
         src_mode = m[1:0];                     // Guard bands alone, then islands.
         src_aud = (m == 2);
         n = 0;
         while (O_RX_ENH !== 1'b1 && n < 80) begin @(negedge I_CLK); n++; end
         chk_bit(O_RX_ENH, 1'b1, "enhanced indication");
         repeat (40) @(negedge I_CLK);
         if (m == 2) chk_bit(O_RX_NO_AUDIO, 1'b0, "audio present");
         src_run = 0;
         src_mode = 2'h0;
         repeat (10) @(negedge I_CLK);
         I_RX_NEW_SRC = 1;
         repeat (8) @(negedge I_CLK);
         chk_bit(O_RX_ENH, 1'b0, "new source");
         I_RX_NEW_SRC = 0;
         src_run = 1;
      end
      // Bring both ends to enhanced first, so the second reset has work to do.
      src_mode = 2'h1;
      I_TX_PROBE = 1;
      @(negedge I_CLK);
      I_TX_SINK_ENH = 1;
      @(negedge I_CLK);
      I_TX_SINK_ENH = 0;
      I_TX_PROBE = 0;
      repeat (40) @(negedge I_CLK);
      chk_bit(O_RX_ENH & O_TX_ENH, 1'b1, "enhanced before reset");
      I_SYS_RST = 1;                            // Reset again mid-run.
      repeat (2) @(negedge I_CLK);
      I_SYS_RST = 0;
      @(negedge I_CLK);
      chk_bit(O_RX_ENH | O_TX_ENH, 1'b0, "second reset");
      give_verdict();
   end
endmodule : llm_mode_ctrl_tb
